// >>> fwa_annunciator.sv
// Purpose: Fault and warning annunciation with code display and enable
// Assumes: Sources are synchronous to i_clk; single word AHB transfers
// Notes: Char codes 0-9 digits, A = F, B = n, F = blank
// What this block does
// [RQ1] Any fault opens relay and stops or brakes stages, per fault type.
// [RQ2] Display shows the active code for as long as it is present.
// [RQ3] A warning shows the same number as its associated fault.
// [RQ4] Warnings alone never open relay nor disable power stages.
// [RQ5] Fault codes prefixed with F, warning codes with n.
// [RQ6] Show prefix, each digit, then a blank, repeating.
// [RQ7] Only highest priority code shown; all active faults stay recorded.
// [RQ8] Full active fault set readable by the controller.
// [RQ9] Identify command blinks the display for 20 s.
// [RQ10] Drive enable needs hardware enable, software enable, no fault.
// [RQ11] Clear command clears latched faults; persisting causes re-raise.
// [RQ12] Code 0 reserved; 101-106 integrity faults; n101, n102 warnings.
// [RQ13] Firmware and gate array version mismatch is code 136.
// [RQ14] Sync frame loss is 125; fieldbus loss is 702.
// [RQ15] Power faults 501, 503, 519, 521, 523, 531, 536, 537.
// [RQ16] Missing input phases 541, 542, 543.
// [RQ17] String current peak 545, continuous 546.
// [RQ18] Over eight nodes 562/561; node count drop 564/565.
// [RQ19] Board faults 621, 623 to 627.
// [RQ20] Lost string packages 628 and 629.
// [RQ21] Each character held a configurable cycle count.
// [RQ22] Fixed priority table; faults beat warnings; ties to lower code.
// [RQ23] Memory and temperature codes sit in the 2xx range.
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
module fwa_annunciator
  import fwa_pkg::*;
#(
  parameter int unsigned IDENT_CYC = FWA_IDENT_CYC,
  parameter int unsigned BLINK_CYC = FWA_BLINK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic [FWA_NCODE-1:0] i_fault_src,
  input wire logic [FWA_NCODE-1:0] i_warn_src,
  input wire logic i_hardware_enable_input,
  output logic o_fault_relay_open,
  output logic o_stage_off,
  output logic o_brake,
  output logic o_drive_en,
  output logic [3:0] o_seg_char,
  output logic o_disp_on
);

  // Bus state
  logic wr_q;
  logic rd_wait_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  // Control and status
  logic software_enable_flag_q;
  logic [31:0] char_time_q;
  logic [FWA_NCODE-1:0] active_fault_list_q;
  logic [FWA_NCODE-1:0] warn_q;
  logic fault_relay_q;
  logic stage_off_q;
  logic brake_q;
  logic drive_en_q;
  // Display
  fwa_state_t st_q;
  logic [31:0] char_tmr_q;
  logic [11:0] cur_code_q;
  logic cur_fault_q;
  logic cur_valid_q;
  logic [3:0] seg_q;
  logic ident_act_q;
  logic [31:0] ident_cnt_q;
  logic [31:0] blink_cnt_q;
  logic blink_q;

  // Address phase and write decode
  wire logic take = i_hsel & i_htrans[1] & i_hready;
  wire logic wr_ctrl = wr_q & (addr_q == FWA_OFS_CTRL);
  wire logic wr_chtime = wr_q & (addr_q == FWA_OFS_CHTIME);
  wire logic clr_pls = wr_ctrl & i_hwdata[FWA_CTL_CLR];
  wire logic ident_pls = wr_ctrl & i_hwdata[FWA_CTL_IDENT];

  // Faults latch, clear yields to a new event
  wire logic [FWA_NCODE-1:0] fault_d =
    (active_fault_list_q & ~{FWA_NCODE{clr_pls}}) | i_fault_src; // RQ11
  wire logic any_fault = |active_fault_list_q;
  wire logic any_warn = |warn_q;

  // Priority selection
  logic [2:0] best_key;
  logic [FWA_IW-1:0] best_idx;
  logic best_fault;
  logic best_valid;

  always_comb begin
    best_key = 3'h0;
    best_idx = '0;
    best_fault = 1'b0;
    best_valid = 1'b0;
    // Walk downward so that ties settle on the lower code
    for (int i = FWA_NCODE - 1; i >= 0; i--) begin
      if (active_fault_list_q[i] &&
          {1'b1, FWA_PRIO[i]} >= best_key) begin // RQ22
        best_key = {1'b1, FWA_PRIO[i]};
        best_idx = FWA_IW'(i);
        best_fault = 1'b1;
        best_valid = 1'b1;
      end else if (warn_q[i] && !best_fault &&
                   {1'b0, FWA_PRIO[i]} >= best_key) begin // RQ7
        best_key = {1'b0, FWA_PRIO[i]};
        best_idx = FWA_IW'(i);
        best_valid = 1'b1;
      end
    end
  end

  // Warnings share the code table with faults
  wire logic [11:0] best_code = FWA_CODE[best_idx]; // RQ3 RQ12 RQ13

  // Read mux
  wire logic [31:0] stat_word = {4'h0, cur_code_q, 10'h000, cur_fault_q,
    cur_valid_q, ident_act_q, drive_en_q, any_warn, any_fault};
  logic [31:0] rd_mux;

  always_comb begin
    if (addr_q == FWA_OFS_CTRL) begin
      rd_mux = {31'h0, software_enable_flag_q};
    end else if (addr_q == FWA_OFS_STAT) begin
      rd_mux = stat_word;
    end else if (addr_q == FWA_OFS_FLT_LO) begin
      rd_mux = active_fault_list_q[31:0]; // RQ8
    end else if (addr_q == FWA_OFS_FLT_HI) begin
      rd_mux = {24'h0, active_fault_list_q[39:32]}; // RQ8
    end else if (addr_q == FWA_OFS_WRN_LO) begin
      rd_mux = warn_q[31:0];
    end else if (addr_q == FWA_OFS_WRN_HI) begin
      rd_mux = {24'h0, warn_q[39:32]};
    end else if (addr_q == FWA_OFS_CHTIME) begin
      rd_mux = char_time_q;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // AHB-Lite slave: writes zero wait, reads one wait state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= 1'b0;
      rd_wait_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= take & i_hwrite;
      rd_wait_q <= take & ~i_hwrite;
      if (take) begin
        addr_q <= {i_haddr[7:2], 2'b00};
      end
    end
  end

  // Read data sampled in the wait cycle, so a write just before is seen
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_wait_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign o_hreadyout = ~rd_wait_q;
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_q;

  // Software registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      software_enable_flag_q <= 1'b0;
      char_time_q <= FWA_CHAR_CYC;
    end else begin
      if (wr_ctrl) begin
        software_enable_flag_q <= i_hwdata[FWA_CTL_SWEN];
      end
      if (wr_chtime) begin
        char_time_q <= i_hwdata; // RQ21
      end
    end
  end

  // Fault record and power actions
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_fault_list_q <= '0;
      warn_q <= '0;
      fault_relay_q <= 1'b0;
      stage_off_q <= 1'b0;
      brake_q <= 1'b0;
      drive_en_q <= 1'b0;
    end else begin
      active_fault_list_q <= fault_d; // RQ7
      warn_q <= i_warn_src;
      // Only faults reach the power path, never warnings
      fault_relay_q <= |fault_d; // RQ1 RQ4
      brake_q <= |(fault_d & FWA_BRAKE_MASK); // RQ1 RQ4
      stage_off_q <= |(fault_d & ~FWA_BRAKE_MASK); // RQ1 RQ4
      drive_en_q <= i_hardware_enable_input & software_enable_flag_q &
                    ~(|fault_d); // RQ10
    end
  end

  assign o_fault_relay_open = fault_relay_q;
  assign o_stage_off = stage_off_q;
  assign o_brake = brake_q;
  assign o_drive_en = drive_en_q;

  // Character sequencer
  wire logic adv = (char_tmr_q == 32'h0000_0000);
  wire logic [31:0] char_load =
    (char_time_q == 32'h0000_0000) ? 32'h0000_0000 : char_time_q - 32'h1;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= FWA_ST_BREAK;
      char_tmr_q <= 32'h0000_0000;
      cur_code_q <= 12'h000;
      cur_fault_q <= 1'b0;
      cur_valid_q <= 1'b0;
    end else if (wr_chtime) begin
      // New hold applies at once; the running char is cut short
      char_tmr_q <= 32'h0000_0000; // RQ21
    end else if (adv) begin
      char_tmr_q <= char_load; // RQ21
      case (st_q)
        FWA_ST_PREFIX: begin
          st_q <= FWA_ST_DIG2; // RQ6
        end
        FWA_ST_DIG2: begin
          st_q <= FWA_ST_DIG1;
        end
        FWA_ST_DIG1: begin
          st_q <= FWA_ST_DIG0;
        end
        FWA_ST_DIG0: begin
          st_q <= FWA_ST_BREAK;
        end
        default: begin
          // Code taken once per pass, so digits never mix two codes
          st_q <= FWA_ST_PREFIX;
          cur_code_q <= best_valid ? best_code : 12'h000; // RQ2 RQ12
          cur_fault_q <= best_fault;
          cur_valid_q <= best_valid;
        end
      endcase
    end else begin
      char_tmr_q <= char_tmr_q - 32'h1;
    end
  end

  logic [3:0] seg_d;

  always_comb begin
    seg_d = FWA_CH_BLANK;
    if (cur_valid_q) begin
      case (st_q)
        FWA_ST_PREFIX: seg_d = cur_fault_q ? FWA_CH_F : FWA_CH_N; // RQ5
        FWA_ST_DIG2: seg_d = cur_code_q[11:8]; // RQ14 RQ15 RQ16
        FWA_ST_DIG1: seg_d = cur_code_q[7:4]; // RQ17 RQ18 RQ19
        FWA_ST_DIG0: seg_d = cur_code_q[3:0]; // RQ20 RQ23
        default: seg_d = FWA_CH_BLANK;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_q <= FWA_CH_BLANK;
    end else begin
      seg_q <= seg_d;
    end
  end

  assign o_seg_char = seg_q;

  // Identify blink; a new command restarts the full period
  wire logic ident_end = ident_act_q & (ident_cnt_q == 32'h0000_0000);
  wire logic blink_flip = (blink_cnt_q == 32'h0000_0000);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ident_act_q <= 1'b0;
      ident_cnt_q <= 32'h0000_0000;
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (ident_pls) begin
      ident_act_q <= 1'b1; // RQ9
      ident_cnt_q <= IDENT_CYC - 1;
      blink_cnt_q <= BLINK_CYC - 1;
      blink_q <= 1'b0;
    end else if (ident_act_q) begin
      ident_act_q <= ~ident_end; // RQ9
      ident_cnt_q <= ident_cnt_q - 32'h1;
      blink_cnt_q <= blink_flip ? BLINK_CYC - 1 : blink_cnt_q - 32'h1;
      blink_q <= blink_flip ? ~blink_q : blink_q;
    end
  end

  assign o_disp_on = ~ident_act_q | blink_q;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_fault_acts;
    (|i_fault_src) |=> o_fault_relay_open && (o_stage_off || o_brake);
  endproperty
  a_fault_acts: assert property (p_fault_acts) // RQ1
    else $error("Fault did not open relay or stop stages");

  property p_warn_only;
    (i_warn_src != '0) && (i_fault_src == '0) &&
      (active_fault_list_q == '0) |=> !o_fault_relay_open &&
      !o_stage_off && !o_brake;
  endproperty
  a_warn_only: assert property (p_warn_only) // RQ4
    else $error("Power path acted without a fault");

  property p_drive_en;
    ##1 o_drive_en == ($past(i_hardware_enable_input) &&
      $past(software_enable_flag_q) && ($past(fault_d) == '0));
  endproperty
  a_drive_en: assert property (p_drive_en) // RQ10
    else $error("Drive enable disagrees with its conditions");

  property p_clear;
    clr_pls && (i_fault_src == '0) |=> active_fault_list_q == '0;
  endproperty
  a_clear: assert property (p_clear) // RQ11
    else $error("Clear left faults latched");

  property p_record;
    (i_fault_src != '0) |=>
      (active_fault_list_q & $past(i_fault_src)) == $past(i_fault_src);
  endproperty
  a_record: assert property (p_record) // RQ7
    else $error("Active fault not recorded");

  property p_prefix;
    st_q == FWA_ST_PREFIX && cur_valid_q |=>
      o_seg_char == (cur_fault_q ? FWA_CH_F : FWA_CH_N);
  endproperty
  a_prefix: assert property (p_prefix) // RQ5
    else $error("Wrong prefix letter");

  property p_hold;
    !adv |=> st_q == $past(st_q);
  endproperty
  a_hold: assert property (p_hold) // RQ21
    else $error("Character advanced before its time");

  property p_order;
    st_q == FWA_ST_PREFIX && adv |=> st_q == FWA_ST_DIG2;
  endproperty
  a_order: assert property (p_order) // RQ6
    else $error("Prefix not followed by first digit");

  property p_ident;
    ident_pls |=> ident_act_q [*8];
  endproperty
  a_ident: assert property (p_ident) // RQ9
    else $error("Identify blink ended early");

  property p_fault_first;
    best_valid && (active_fault_list_q != '0) |-> best_fault;
  endproperty
  a_fault_first: assert property (p_fault_first) // RQ22
    else $error("Warning chosen over a fault");

endmodule // fwa_annunciator

// >>> fwa_pkg.sv
// Purpose: Shared constants for the fault and warning annunciator
// Assumes: 20 MHz system clock, AHB-Lite register access
// Notes: Codes are held as three BCD digits
package fwa_pkg;

  localparam int FWA_NCODE = 40;
  localparam int FWA_IW = 6;

  // Code table, ascending; index is the bit in the fault and warning sets
  localparam logic [11:0] FWA_CODE [FWA_NCODE] = '{
    12'h101, 12'h102, 12'h103, 12'h104, 12'h105, 12'h106, 12'h125,
    12'h136, 12'h201, 12'h202, 12'h203, 12'h204, 12'h234, 12'h240,
    12'h501, 12'h503, 12'h519, 12'h521, 12'h523, 12'h531, 12'h536,
    12'h537, 12'h541, 12'h542, 12'h543, 12'h545, 12'h546, 12'h561,
    12'h562, 12'h564, 12'h565, 12'h621, 12'h623, 12'h624, 12'h625,
    12'h626, 12'h627, 12'h628, 12'h629, 12'h702};

  // Display priority per code, higher wins
  localparam logic [1:0] FWA_PRIO [FWA_NCODE] = '{
    2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h3, 2'h3, 2'h3,
    2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1,
    2'h1, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h1};

  // Set bit: fault brakes the load, clear bit: stage switched off
  localparam logic [39:0] FWA_BRAKE_MASK = 40'h00_7FC0_0000;

  // Register byte offsets
  localparam logic [7:0] FWA_OFS_CTRL = 8'h00;
  localparam logic [7:0] FWA_OFS_STAT = 8'h04;
  localparam logic [7:0] FWA_OFS_FLT_LO = 8'h08;
  localparam logic [7:0] FWA_OFS_FLT_HI = 8'h0C;
  localparam logic [7:0] FWA_OFS_WRN_LO = 8'h10;
  localparam logic [7:0] FWA_OFS_WRN_HI = 8'h14;
  localparam logic [7:0] FWA_OFS_CHTIME = 8'h18;

  // Control bit positions
  localparam int FWA_CTL_SWEN = 0;
  localparam int FWA_CTL_CLR = 1;
  localparam int FWA_CTL_IDENT = 2;

  // Display characters
  localparam logic [3:0] FWA_CH_F = 4'hA;
  localparam logic [3:0] FWA_CH_N = 4'hB;
  localparam logic [3:0] FWA_CH_BLANK = 4'hF;

  // Timing
  localparam int FWA_CLK_KHZ = 20000;
  localparam int FWA_IDENT_MS = 20000;
  localparam int FWA_BLINK_MS = 500;
  localparam int FWA_CHAR_MS = 500;
  localparam int FWA_IDENT_CYC = FWA_IDENT_MS * FWA_CLK_KHZ;
  localparam int FWA_BLINK_CYC = FWA_BLINK_MS * FWA_CLK_KHZ;
  localparam logic [31:0] FWA_CHAR_CYC = 32'(FWA_CHAR_MS * FWA_CLK_KHZ);

  typedef enum logic [2:0] {
    FWA_ST_PREFIX,
    FWA_ST_DIG2,
    FWA_ST_DIG1,
    FWA_ST_DIG0,
    FWA_ST_BREAK
  } fwa_state_t;

endpackage

// >>> fwa_string_model.sv
// Purpose: Power string stand-in that drives causes and reacts to stops
// Assumes: Causes change only just after a rising clock edge
// Notes: Torque shows only while enabled, unbraked and stage on
module fwa_string_model
  import fwa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_stage_off,
  input wire logic i_brake,
  input wire logic i_drive_en,
  output logic [FWA_NCODE-1:0] o_fault_src,
  output logic [FWA_NCODE-1:0] o_warn_src,
  output logic o_torque
);
  initial begin
    o_fault_src = '0;
    o_warn_src = '0;
  end
  assign o_torque = i_drive_en & ~i_stage_off & ~i_brake;

  task put(input logic [FWA_NCODE-1:0] f, input logic [FWA_NCODE-1:0] w);
    @(posedge i_clk);
    o_fault_src <= f;
    o_warn_src <= w;
  endtask
endmodule // fwa_string_model

// >>> fwa_annunciator_tb_top.sv
// Purpose: Self-checking bench for the fault and warning annunciator
// Assumes: Char hold shortened to 4 cycles, identify to 200 cycles
// Notes: Bus tasks wait on hready, bounded only by the cycle ceiling
module fwa_annunciator_tb_top
  import fwa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LIMIT = 20000;
  localparam logic [11:0] CODES [40] = '{
    12'h101, 12'h102, 12'h103, 12'h104, 12'h105, 12'h106, 12'h125,
    12'h136, 12'h201, 12'h202, 12'h203, 12'h204, 12'h234, 12'h240,
    12'h501, 12'h503, 12'h519, 12'h521, 12'h523, 12'h531, 12'h536,
    12'h537, 12'h541, 12'h542, 12'h543, 12'h545, 12'h546, 12'h561,
    12'h562, 12'h564, 12'h565, 12'h621, 12'h623, 12'h624, 12'h625,
    12'h626, 12'h627, 12'h628, 12'h629, 12'h702};
  logic clk, rst_n, hsel, hwrite, hready, hresp, hw_en;
  logic relay, stg_off, brake, drv_en, disp_on, torque;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0] seg;
  logic [39:0] fsrc, wsrc;
  int error_cnt, n_compared, cyc, k;

  fwa_annunciator #(.IDENT_CYC(200), .BLINK_CYC(20)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_fault_src(fsrc),
    .i_warn_src(wsrc), .i_hardware_enable_input(hw_en),
    .o_fault_relay_open(relay), .o_stage_off(stg_off), .o_brake(brake),
    .o_drive_en(drv_en), .o_seg_char(seg), .o_disp_on(disp_on));

  fwa_string_model str (
    .i_clk(clk), .i_stage_off(stg_off), .i_brake(brake),
    .i_drive_en(drv_en), .o_fault_src(fsrc), .o_warn_src(wsrc),
    .o_torque(torque));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single word transfer; read data taken at the data phase ready edge
  task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk(hresp, 0);
  endtask

  // Syncs to a sequence start, then checks every cycle of all five chars
  task show(input logic [3:0] pre, input logic [11:0] code);
    logic [3:0] e [5];
    e = '{pre, code[11:8], code[7:4], code[3:0], FWA_CH_BLANK};
    k = 0;
    while (seg !== FWA_CH_BLANK && k < 100) begin
      @(posedge clk);
      k++;
    end
    while (seg === FWA_CH_BLANK && k < 200) begin
      @(posedge clk);
      k++;
    end
    for (int i = 0; i < 20; i++) begin
      chk(seg, e[i / 4]);
      @(posedge clk);
    end
  endtask

  // Cause removed first, otherwise the clear would lose
  task clear();
    str.put('0, '0);
    rw(1'b1, FWA_OFS_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk(relay, 0);
  endtask

  initial begin
    logic b;
    hsel = 1'b0; hwrite = 1'b0; haddr = 8'h00; htrans = 2'h0;
    hwdata = 32'h0; hw_en = 1'b0; rst_n = 1'b0;
    error_cnt = 0; n_compared = 0; cyc = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(seg, FWA_CH_BLANK);
    chk(disp_on, 1);
    rw(1'b0, FWA_OFS_CHTIME, 32'h0);
    chk(rd, 32'h0098_9680);
    rw(1'b0, 8'h1C, 32'h0);
    chk(rd, 0);
    rw(1'b1, FWA_OFS_CHTIME, 32'h4);
    hw_en <= 1'b1;
    rw(1'b1, FWA_OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk(drv_en, 1);
    chk(torque, 1);
    hw_en <= 1'b0;
    repeat (2) @(posedge clk);
    chk(drv_en, 0);
    hw_en <= 1'b1;
    rw(1'b1, FWA_OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk(drv_en, 0);
    rw(1'b1, FWA_OFS_CTRL, 32'h1);
    $display("test enable done");
    str.put('0, 40'h1 << 6);
    rw(1'b0, FWA_OFS_STAT, 32'h0);
    chk(rd[1:0], 2'b10);
    chk(relay, 0);
    chk(stg_off, 0);
    chk(drv_en, 1);
    show(FWA_CH_N, 12'h125);
    str.put('0, '0);
    $display("test warning done");
    for (int i = 0; i < 40; i++) begin
      b = (i >= 22 && i <= 30);
      str.put(40'h1 << i, '0);
      repeat (2) @(posedge clk);
      chk(relay, 1);
      chk(brake, b);
      chk(stg_off, !b);
      chk(drv_en, 0);
      rw(1'b0, (i < 32) ? FWA_OFS_FLT_LO : FWA_OFS_FLT_HI, 32'h0);
      chk(rd, 32'h1 << (i % 32));
      show(FWA_CH_F, CODES[i]);
      clear();
    end
    $display("test codes done");
    str.put(40'h1 << 14, '0);
    rw(1'b1, FWA_OFS_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    chk(relay, 1);
    clear();
    str.put(40'h1 << 14, '0);
    str.put('0, '0);
    repeat (2) @(posedge clk);
    chk(relay, 1);
    clear();
    $display("test clear done");
    str.put((40'h1 << 22) | (40'h1 << 31), '0);
    rw(1'b0, FWA_OFS_FLT_LO, 32'h0);
    chk(rd, 32'h8040_0000);
    show(FWA_CH_F, 12'h621);
    rw(1'b0, FWA_OFS_STAT, 32'h0);
    chk(rd[27:16], 12'h621);
    clear();
    str.put((40'h1 << 14) | (40'h1 << 15), '0);
    show(FWA_CH_F, 12'h501);
    clear();
    str.put(40'h1 << 39, 40'h1);
    show(FWA_CH_F, 12'h702);
    clear();
    str.put('0, 40'h41);
    show(FWA_CH_N, 12'h101);
    clear();
    $display("test priority done");
    rw(1'b1, FWA_OFS_CTRL, 32'h5);
    k = 0;
    repeat (260) begin
      @(posedge clk);
      if (disp_on === 1'b0) k++;
    end
    chk(k, 100);
    chk(disp_on, 1);
    rw(1'b0, FWA_OFS_STAT, 32'h0);
    chk(rd[3], 0);
    $display("test identify done");
    give_verdict();
  end
endmodule // fwa_annunciator_tb_top
